// ===== include/cpp_pkg.sv
// Constants shared by the pipelined coprocessor port.
// Assumes one system clock shared by the core, this port and the coprocessor.
package cpp_pkg;

  // Bus widths
  localparam int CPP_DATA_W  = 32;
  localparam int CPP_INSTR_W = 32;

  // Handshake codes, per stage
  localparam logic [1:0] CPP_HS_ABSENT = 2'h2;
  localparam logic [1:0] CPP_HS_WAIT   = 2'h0;
  localparam logic [1:0] CPP_HS_GO     = 2'h1;
  localparam logic [1:0] CPP_HS_LAST   = 2'h3;

  // Values after reset of the registered outputs
  localparam logic [31:0] CPP_RST_WORD    = 32'h0000_0000;
  localparam logic        CPP_RST_ADV_EN  = 1'b0;
  localparam logic        CPP_RST_TAKE_N  = 1'b1;
  localparam logic        CPP_RST_COMMIT  = 1'b0;
  localparam logic        CPP_RST_CANCEL  = 1'b0;
  localparam logic        CPP_RST_COMPACT = 1'b0;
  localparam logic        CPP_RST_PRIV    = 1'b0;

  // Width of the packed output stage: advance, take, commit, cancel, isa, priv, instr, data
  localparam int CPP_OUT_W = 6 + CPP_INSTR_W + CPP_DATA_W;

  // Catch-up stall length, in cycles
  localparam int CPP_STALL_CYCLES = 1;

  typedef enum logic [1:0] {
    CPP_ST_IDLE,
    CPP_ST_STALL,
    CPP_ST_SYNC
  } cpp_sync_state_t;

endpackage

// ===== hdl/cpp_pipe_reg.sv
// One-cycle register stage with a constant reset value.
// Assumes the data input is on the same clock as sys_clk.
`timescale 1ns/1ps
module cpp_pipe_reg #(
  parameter int         W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] next_q;

  // Next value is the input
  always_comb begin
    next_q = d;
  end

  // Register stage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= RST_VAL;
    end else begin
      q <= next_q;
    end
  end

endmodule // cpp_pipe_reg

// ===== hdl/cpp_port.sv
// Pipelined coprocessor port: core-side signals in, registered follower signals out,
// follower handshakes merged back into the core with a one-cycle catch-up stall.
// Assumes core and coprocessor run on sys_clk; coprocessor inputs are same-domain logic.
//
// How it works
// - Coprocessor pipeline follows one cycle behind the core pipeline.
// - All outputs to the coprocessor come straight from flip-flops.
// - Advance enable high at a clock edge lets the follower step.
// - Fetched instructions go out on a 32-bit instruction bus.
// - Data to the coprocessor goes out on a 32-bit bus.
// - Commit is high when a coprocessor instruction in Execute must execute.
// - Late cancel only in cycles after a data abort.
// - Instruction-set output high for compact set, low for full set.
// - Take-instruction low with advance high loads the instruction bus.
// - Privilege output low for user, high for privileged mode.
// - Decoded coprocessor instruction stalls the core one cycle via handshakes.
// - After the stall, tell the coprocessor of each Decode to Execute move.
// - Absent Decode handshake after the stall makes the core take the undefined-instruction trap.
`timescale 1ns/1ps
module cpp_port
  import cpp_pkg::*;
#(
  parameter int DATA_W  = CPP_DATA_W,
  parameter int INSTR_W = CPP_INSTR_W
) (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  // Core side
  input  wire logic               core_advance,
  input  wire logic               core_fetch_req_n,
  input  wire logic [INSTR_W-1:0] core_instr,
  input  wire logic [DATA_W-1:0]  core_store_data,
  input  wire logic               core_exec_pass,
  input  wire logic               core_late_cancel,
  input  wire logic               core_prev_data_abort,
  input  wire logic               core_compact_isa,
  input  wire logic               core_privileged,
  input  wire logic               core_cop_in_decode,
  output logic [1:0]              core_hs_decode,
  output logic [1:0]              core_hs_execute,
  output logic                    core_undef_trap,
  output logic [DATA_W-1:0]       core_load_data,
  // Coprocessor side
  output logic                    follower_advance_en,
  output logic [INSTR_W-1:0]      cop_instr_bus,
  output logic [DATA_W-1:0]       cop_data_to_cop,
  input  wire logic [DATA_W-1:0]  cop_data_from_cop,
  output logic                    exec_commit,
  output logic                    late_abort_cancel,
  input  wire logic [1:0]         handshake_decode_stage,
  input  wire logic [1:0]         handshake_execute_stage,
  output logic                    compact_isa_state,
  output logic                    instr_take_n,
  output logic                    privilege_level
);

  localparam int OW = 6 + INSTR_W + DATA_W;
  localparam logic [OW-1:0] OUT_RST = {CPP_RST_ADV_EN, CPP_RST_TAKE_N, CPP_RST_COMMIT, CPP_RST_CANCEL,
                                       CPP_RST_COMPACT, CPP_RST_PRIV, CPP_RST_WORD[INSTR_W-1:0],
                                       CPP_RST_WORD[DATA_W-1:0]};

  cpp_sync_state_t    state;
  cpp_sync_state_t    next_state;
  logic               started;
  logic               next_started;
  logic [DATA_W-1:0]  next_core_load_data;
  logic               commit_d;
  logic               cancel_d;
  logic [OW-1:0]      out_d;
  logic [OW-1:0]      out_q;

  // First fetch opens the commit and cancel paths
  always_comb begin
    next_started = started | ~core_fetch_req_n;
    commit_d     = started & core_exec_pass & core_advance;
    cancel_d     = started & core_late_cancel & core_prev_data_abort;
  end

  // Packed outputs delayed one cycle behind the core
  always_comb begin
    out_d = {core_advance, core_fetch_req_n, commit_d, cancel_d,
             core_compact_isa, core_privileged,
             core_instr, core_store_data};
  end

  cpp_pipe_reg #(
    .W       (OW),
    .RST_VAL (OUT_RST)
  ) u_out_stage (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .d       (out_d),
    .q       (out_q)
  );

  // Unpack registered outputs
  assign follower_advance_en = out_q[OW-1];
  assign instr_take_n        = out_q[OW-2];
  assign exec_commit         = out_q[OW-3];
  assign late_abort_cancel   = out_q[OW-4];
  assign compact_isa_state   = out_q[OW-5];
  assign privilege_level     = out_q[OW-6];
  assign cop_instr_bus       = out_q[DATA_W+INSTR_W-1:DATA_W];
  assign cop_data_to_cop     = out_q[DATA_W-1:0];

  // Catch-up sequencing for a decoded coprocessor instruction
  always_comb begin
    next_state = state;
    case (state)
      CPP_ST_IDLE: begin
        if (core_cop_in_decode) begin
          next_state = CPP_ST_STALL;
        end
      end
      CPP_ST_STALL: begin
        // Follower has caught up; the core may already move on
        if (core_advance) begin
          next_state = CPP_ST_IDLE;
        end else begin
          next_state = CPP_ST_SYNC;
        end
      end
      CPP_ST_SYNC: begin
        if (core_advance) begin
          next_state = CPP_ST_IDLE;
        end
      end
      default: begin
        next_state = CPP_ST_IDLE;
      end
    endcase
  end

  // Load data captured from the coprocessor
  always_comb begin
    next_core_load_data = cop_data_from_cop;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state          <= CPP_ST_IDLE;
      started        <= 1'b0;
      core_load_data <= CPP_RST_WORD[DATA_W-1:0];
    end else begin
      state          <= next_state;
      started        <= next_started;
      core_load_data <= next_core_load_data;
    end
  end

  // Handshakes to the core, forced to wait for the one cycle the follower lags
  always_comb begin
    if (core_cop_in_decode && (state == CPP_ST_IDLE)) begin
      core_hs_decode  = CPP_HS_WAIT;
      core_hs_execute = CPP_HS_WAIT;
    end else begin
      core_hs_decode  = handshake_decode_stage;
      core_hs_execute = handshake_execute_stage;
    end
    core_undef_trap = (state != CPP_ST_IDLE) && core_cop_in_decode
                      && (handshake_decode_stage == CPP_HS_ABSENT);
  end

  // Checks
  property p_follow_lag;
    @(posedge sys_clk) disable iff (!reset_n)
    follower_advance_en == $past(core_advance);
  endproperty
  a_follow_lag: assert property (p_follow_lag) else $error("advance enable not one cycle late");

  property p_instr_bus;
    @(posedge sys_clk) disable iff (!reset_n)
    !core_fetch_req_n |=> (cop_instr_bus == $past(core_instr)) && !instr_take_n;
  endproperty
  a_instr_bus: assert property (p_instr_bus) else $error("instruction not presented");

  property p_data_out;
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 cop_data_to_cop == $past(core_store_data);
  endproperty
  a_data_out: assert property (p_data_out) else $error("store data not forwarded");

  property p_commit;
    @(posedge sys_clk) disable iff (!reset_n)
    exec_commit |-> $past(core_exec_pass) && $past(core_advance) && $past(started);
  endproperty
  a_commit: assert property (p_commit) else $error("commit without pass");

  property p_cancel;
    @(posedge sys_clk) disable iff (!reset_n)
    late_abort_cancel |-> $past(core_prev_data_abort);
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel without prior abort");

  property p_state_bits;
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 (compact_isa_state == $past(core_compact_isa)) && (privilege_level == $past(core_privileged));
  endproperty
  a_state_bits: assert property (p_state_bits) else $error("isa or privilege not forwarded");

  sequence s_new_cop;
    (state == CPP_ST_IDLE) && core_cop_in_decode;
  endsequence
  sequence s_caught_up;
    (state == CPP_ST_STALL) && (core_hs_decode == handshake_decode_stage);
  endsequence
  property p_catch_up;
    @(posedge sys_clk) disable iff (!reset_n)
    s_new_cop |-> (core_hs_decode == CPP_HS_WAIT) ##1 s_caught_up;
  endproperty
  a_catch_up: assert property (p_catch_up) else $error("catch-up stall missing");

  property p_undef;
    @(posedge sys_clk) disable iff (!reset_n)
    (state != CPP_ST_IDLE && core_cop_in_decode && handshake_decode_stage == CPP_HS_ABSENT) |-> core_undef_trap;
  endproperty
  a_undef: assert property (p_undef) else $error("absent did not trap");

  property p_quiet_start;
    @(posedge sys_clk) disable iff (!reset_n)
    !started |=> !exec_commit && !late_abort_cancel;
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("commit or cancel before first fetch");

endmodule // cpp_port

// ===== sim/cpp_cop_model.sv
// Behavioural coprocessor pipeline follower facing the port.
// Assumes one sys_clk; handshakes come from the low bits of the Decode and Execute words.
`timescale 1ns/1ps
module cpp_cop_model
  import cpp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        follower_advance_en,
  input  wire logic        instr_take_n,
  input  wire logic [31:0] cop_instr_bus,
  input  wire logic        late_abort_cancel,
  output logic [31:0]      cop_data_from_cop,
  output logic [1:0]       handshake_decode_stage,
  output logic [1:0]       handshake_execute_stage
);
  logic [31:0] dec_q;
  logic [31:0] exe_q;
  // Follower steps only on enabled edges
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_q <= 32'h0000_0000;
      exe_q <= 32'h0000_0000;
    end else if (follower_advance_en) begin
      if (!instr_take_n) dec_q <= cop_instr_bus;
      if (!late_abort_cancel) exe_q <= dec_q;
    end
  end
  // Single coprocessor, so merged code equals its own
  assign handshake_decode_stage  = dec_q[1:0];
  assign handshake_execute_stage = exe_q[1:0];
  assign cop_data_from_cop       = dec_q ^ 32'hA5A5_5A5A;
endmodule // cpp_cop_model

// ===== sim/cpp_port_bench.sv
// Self-checking bench for the coprocessor port with a follower model.
// Assumes inputs change at the falling edge; registered outputs checked one cycle later, at the next falling edge.
`timescale 1ns/1ps
module cpp_port_bench
  import cpp_pkg::*;
;
  logic sys_clk, reset_n, core_advance, core_fetch_req_n, core_exec_pass, core_late_cancel;
  logic core_prev_data_abort, core_compact_isa, core_privileged, core_cop_in_decode;
  logic [31:0] core_instr, core_store_data, core_load_data, cop_instr_bus, cop_data_to_cop, cop_data_from_cop;
  logic [1:0] core_hs_decode, core_hs_execute, handshake_decode_stage, handshake_execute_stage;
  logic core_undef_trap, follower_advance_en, exec_commit, late_abort_cancel;
  logic compact_isa_state, instr_take_n, privilege_level;
  int bad_count = 0;
  int n_tests = 0;
  cpp_port dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .core_advance(core_advance),
    .core_fetch_req_n(core_fetch_req_n), .core_instr(core_instr), .core_store_data(core_store_data),
    .core_exec_pass(core_exec_pass), .core_late_cancel(core_late_cancel),
    .core_prev_data_abort(core_prev_data_abort), .core_compact_isa(core_compact_isa),
    .core_privileged(core_privileged), .core_cop_in_decode(core_cop_in_decode),
    .core_hs_decode(core_hs_decode), .core_hs_execute(core_hs_execute), .core_undef_trap(core_undef_trap),
    .core_load_data(core_load_data), .follower_advance_en(follower_advance_en),
    .cop_instr_bus(cop_instr_bus), .cop_data_to_cop(cop_data_to_cop), .cop_data_from_cop(cop_data_from_cop),
    .exec_commit(exec_commit), .late_abort_cancel(late_abort_cancel),
    .handshake_decode_stage(handshake_decode_stage), .handshake_execute_stage(handshake_execute_stage),
    .compact_isa_state(compact_isa_state), .instr_take_n(instr_take_n), .privilege_level(privilege_level));
  cpp_cop_model cop_u (.sys_clk(sys_clk), .reset_n(reset_n), .follower_advance_en(follower_advance_en),
    .instr_take_n(instr_take_n), .cop_instr_bus(cop_instr_bus), .late_abort_cancel(late_abort_cancel),
    .cop_data_from_cop(cop_data_from_cop), .handshake_decode_stage(handshake_decode_stage),
    .handshake_execute_stage(handshake_execute_stage));
  // Clock, 8 ns period
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t bit got %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t word got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Outputs idle after reset; commit and cancel refused before any fetch
  task automatic t_reset();
    chk_bit(instr_take_n, 1'b1);
    @(negedge sys_clk);
    {core_exec_pass, core_late_cancel, core_prev_data_abort, core_advance} = 4'hF;
    @(negedge sys_clk);
    chk_bit(exec_commit, 1'b0);
    chk_bit(late_abort_cancel, 1'b0);
    {core_exec_pass, core_late_cancel, core_prev_data_abort, core_advance} = 4'h0;
  endtask
  // One fetch, outputs one cycle later, load data back from the follower
  task automatic t_fetch(input logic [31:0] w, input logic [31:0] d, input logic isa, input logic priv);
    @(negedge sys_clk);
    {core_advance, core_fetch_req_n, core_instr, core_store_data} = {2'h2, w, d};
    {core_compact_isa, core_privileged} = {isa, priv};
    @(negedge sys_clk);
    {core_advance, core_fetch_req_n} = 2'h1;
    chk_w(cop_instr_bus, w);
    chk_w(cop_data_to_cop, d);
    chk_bit(instr_take_n, 1'b0);
    chk_bit(follower_advance_en, 1'b1);
    chk_bit(compact_isa_state, isa);
    chk_bit(privilege_level, priv);
    repeat (2) @(negedge sys_clk);
    chk_w(core_load_data, w ^ 32'hA5A5_5A5A);
  endtask
  // Commit follows pass, cancel needs a preceding abort
  task automatic t_commit();
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      {core_prev_data_abort, core_late_cancel, core_exec_pass, core_advance} = {i[2:0], 1'b1};
      @(negedge sys_clk);
      chk_bit(exec_commit, i[0]);
      chk_bit(late_abort_cancel, i[1] & i[2]);
    end
    {core_prev_data_abort, core_late_cancel, core_exec_pass, core_advance} = 4'h0;
  endtask
  // Catch-up stall for each handshake code, then pass-through
  task automatic t_stall();
    logic [1:0] codes [4];
    logic [1:0] p;
    codes = '{CPP_HS_ABSENT, CPP_HS_WAIT, CPP_HS_GO, CPP_HS_LAST};
    p = CPP_HS_WAIT;
    t_fetch({30'h0, p}, 32'h0, 1'b0, 1'b0);
    foreach (codes[k]) begin
      t_fetch({28'h1234_567, 2'h0, codes[k]}, 32'hFFFF_0000, 1'b1, 1'b1);
      @(negedge sys_clk);
      core_cop_in_decode = 1'b1;
      #1;
      chk_w({30'h0, core_hs_decode}, {30'h0, CPP_HS_WAIT});
      chk_w({30'h0, core_hs_execute}, {30'h0, CPP_HS_WAIT});
      @(negedge sys_clk);
      chk_w({30'h0, core_hs_decode}, {30'h0, codes[k]});
      chk_w({30'h0, core_hs_execute}, {30'h0, p});
      chk_bit(core_undef_trap, codes[k] == CPP_HS_ABSENT);
      @(negedge sys_clk);
      chk_w({30'h0, core_hs_decode}, {30'h0, codes[k]});
      core_advance = 1'b1;
      @(negedge sys_clk);
      {core_advance, core_cop_in_decode} = 2'h0;
      p = codes[k];
    end
    // Core leaves Decode in the first synced cycle; the next one stalls again
    @(negedge sys_clk);
    core_cop_in_decode = 1'b1;
    @(negedge sys_clk);
    core_advance = 1'b1;
    @(negedge sys_clk);
    core_advance = 1'b0;
    #1;
    chk_w({30'h0, core_hs_decode}, {30'h0, CPP_HS_WAIT});
    core_cop_in_decode = 1'b0;
  endtask
  // Watchdog for a hung run
  initial begin
    #20000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
  // Main sequence
  initial begin
    {reset_n, core_advance, core_fetch_req_n, core_exec_pass, core_late_cancel} = 5'h04;
    {core_prev_data_abort, core_compact_isa, core_privileged, core_cop_in_decode} = 4'h0;
    {core_instr, core_store_data} = 64'h0;
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_fetch(32'hDEAD_BEEF, 32'h0123_4567, 1'b1, 1'b0);
    t_fetch(32'h2152_4110, 32'hFEDC_BA98, 1'b0, 1'b1);
    t_commit();
    t_stall();
    give_verdict();
  end
endmodule // cpp_port_bench
